// *** caf_pkg.sv ***
// caf_pkg: register map, field layout and reset values of the
// acceptance filter. assumes a 32-bit apb with 12-bit byte addresses.
// Contract
// - filter extended id low bits must match
// - mask standard bits choose compared id bits
// - mask extended bits choose compared eid bits
// - strict type mask: frame type must match
// - non-strict: match standard or extended alike
// - mask bits 4 and 2 read zero
// - mask source 00/01/10 picks mask 0-2
// - select fields: filter k at bits 2k+1:2k
// - pointer 1111 means fifo, else buffer
// - pointer register nibbles hold four filters
// - select/pointer reset zero, ids undefined
// - filter standard id at bits 15-5
// - filter frame type bit at bit 3
// - sixteen filter enables, reset to one
// - unmasked filter accepts standard frames only
package caf_pkg;
    localparam int          NUM_FILTERS     = 16;          // filter count
    localparam int          NUM_MASKS       = 3;           // mask count
    localparam int          ADDR_W          = 12;          // apb address width
    // register byte addresses
    localparam logic [11:0] ADDR_FILT_EN    = 12'h000;     // filter enables
    localparam logic [11:0] ADDR_MSEL_LO    = 12'h004;     // mask select 0-7
    localparam logic [11:0] ADDR_MSEL_HI    = 12'h008;     // mask select 8-15
    localparam logic [11:0] ADDR_BPTR_BASE  = 12'h00c;     // four pointer regs
    localparam logic [11:0] ADDR_MSID_BASE  = 12'h020;     // mask std id 0-2
    localparam logic [11:0] ADDR_MEID_BASE  = 12'h030;     // mask ext id 0-2
    localparam logic [11:0] ADDR_FSID_BASE  = 12'h040;     // filter std id 0-15
    localparam logic [11:0] ADDR_FEID_BASE  = 12'h080;     // filter ext id 0-15
    localparam logic [11:0] ADDR_STATUS     = 12'h0c0;     // last result
    localparam logic [11:0] ADDR_HITS       = 12'h0c4;     // last hit vector
    // standard id register layout
    localparam int          SID_HI          = 15;          // std id msb
    localparam int          SID_LO          = 5;           // std id lsb
    localparam int          TYPE_BIT        = 3;           // type / strict bit
    localparam int          EIDH_HI         = 1;           // eid 17:16 msb
    localparam logic [15:0] SID_REG_MASK    = 16'hffeb;    // bits 4,2 absent
    // field codes and resets
    localparam logic [3:0]  BPTR_FIFO       = 4'hf;        // pointer to fifo
    localparam logic [1:0]  MSEL_RESERVED   = 2'h3;        // reserved source
    localparam logic [15:0] FILT_EN_RESET   = 16'hffff;    // all enabled
    localparam logic [15:0] ZERO_RESET      = 16'h0000;    // select/pointer
    // status layout
    localparam int          ST_ACCEPT       = 15;          // frame accepted
    localparam int          ST_FIFO         = 14;          // went to fifo
    localparam int          ST_FILT_LO      = 8;           // winning filter
    localparam int          ST_BUF_LO       = 0;           // buffer index
endpackage

// *** caf_filter_match.sv ***
// caf_filter_match: compare of one filter against one frame id.
// assumes the chosen mask is already steered to it.
`timescale 1ns/100ps
module caf_filter_match (
    input  wire logic        enable,     // filter enable bit
    input  wire logic [15:0] filt_sid,   // filter std id register
    input  wire logic [15:0] filt_eid,   // filter ext id register
    input  wire logic [15:0] mask_sid,   // mask std id register
    input  wire logic [15:0] mask_eid,   // mask ext id register
    input  wire logic        frame_ide,  // frame is extended
    input  wire logic [10:0] frame_sid,  // frame std id
    input  wire logic [17:0] frame_eid,  // frame ext id
    output logic             hit         // filter accepts frame
);
    logic [10:0] f_sid;      // stored std id
    logic [17:0] f_eid;      // stored full ext id
    logic [10:0] m_sid;      // std compare mask
    logic [17:0] m_eid;      // ext compare mask
    logic        sid_ok;     // std part agrees
    logic        eid_ok;     // ext part agrees
    logic        type_ok;    // frame type allowed
    logic        no_mask;    // mask selects nothing

    assign f_sid   = filt_sid[caf_pkg::SID_HI:caf_pkg::SID_LO];
    assign f_eid   = {filt_sid[caf_pkg::EIDH_HI:0], filt_eid};
    assign m_sid   = mask_sid[caf_pkg::SID_HI:caf_pkg::SID_LO];
    assign m_eid   = {mask_sid[caf_pkg::EIDH_HI:0], mask_eid};
    // masked bits must agree, zero mask bits are don't care
    assign sid_ok  = ((frame_sid ^ f_sid) & m_sid) == 11'h000;
    assign eid_ok  = ((frame_eid ^ f_eid) & m_eid) == 18'h00000;
    // strict mode ties frame type to the filter type bit
    assign type_ok = !mask_sid[caf_pkg::TYPE_BIT]
                     || (frame_ide == filt_sid[caf_pkg::TYPE_BIT]);
    assign no_mask = (m_sid == 11'h000) && (m_eid == 18'h00000);
    // standard frames compare sid only, extended frames the full id
    assign hit     = enable && type_ok && sid_ok
                     && (!frame_ide || eid_ok)
                     && !(no_mask && frame_ide);
endmodule

// *** caf_accept_filter.sv ***
// caf_accept_filter: sixteen acceptance filters with three masks,
// apb register file and a registered routing result per frame.
// assumes the protocol engine gives one id pulse per frame on ref_clk.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
module caf_accept_filter #(
    parameter int N_FILT = caf_pkg::NUM_FILTERS,  // filter count
    parameter int N_MASK = caf_pkg::NUM_MASKS     // mask count
) (
    input  wire logic        ref_clk,        // 200 mhz clock
    input  wire logic        rst,            // sync reset, high
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb write
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic [31:0]      prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error
    input  wire logic        frame_valid,    // id strobe, one cycle
    input  wire logic        frame_ide,      // extended frame
    input  wire logic [10:0] frame_sid,      // standard id
    input  wire logic [17:0] frame_eid,      // extended id
    output logic             result_valid,   // result strobe
    output logic             result_accept,  // some filter hit
    output logic             result_to_fifo, // stored in fifo
    output logic [3:0]       result_buffer,  // buffer index 0-14
    output logic [3:0]       result_filter   // winning filter
);
    // the map and pointer layout only fit these sizes
    if (N_FILT != 16 || N_MASK != 3) begin : g_check
        $error("caf_accept_filter supports 16 filters and 3 masks");
    end

    // configuration storage
    logic [15:0] filt_en_reg;               // filter enables
    logic [15:0] msel_lo_reg;               // mask select 0-7
    logic [15:0] msel_hi_reg;               // mask select 8-15
    logic [15:0] bptr_reg  [4];             // buffer pointers
    logic [15:0] msid_reg  [N_MASK];        // mask std id
    logic [15:0] meid_reg  [N_MASK];        // mask ext id
    logic [15:0] fsid_reg  [N_FILT];        // filter std id
    logic [15:0] feid_reg  [N_FILT];        // filter ext id
    // result state
    logic [15:0] hits_reg;                  // last hit vector
    logic        valid_reg;                 // result strobe
    logic        accept_reg;                // accepted
    logic        fifo_reg;                  // to fifo
    logic [3:0]  buf_reg;                   // buffer index
    logic [3:0]  win_reg;                   // winning filter
    // bus decode
    logic        wr_en;                     // write at access edge
    logic        rd_setup;                  // read setup cycle
    logic        addr_ok;                   // address mapped
    logic [31:0] rd_next;                   // read mux
    logic [31:0] prdata_reg;                // read data flop
    logic [3:0]  word;                      // word within block
    // evaluation
    logic [N_FILT-1:0] hit;                 // per-filter hits
    logic [31:0] msel_all;                  // both select regs
    logic [63:0] bptr_all;                  // all pointer nibbles
    logic        any_hit;                   // some hit
    logic [3:0]  win_next;                  // lowest hit index
    logic [3:0]  ptr_next;                  // its pointer

    assign word     = paddr[5:2];
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable;
    assign msel_all = {msel_hi_reg, msel_lo_reg};
    assign bptr_all = {bptr_reg[3], bptr_reg[2], bptr_reg[1], bptr_reg[0]};

    // address decode for every mapped word
    always_comb begin
        addr_ok = 1'b0;
        if (paddr[1:0] == 2'h0) begin
            if (paddr == caf_pkg::ADDR_FILT_EN || paddr == caf_pkg::ADDR_MSEL_LO
                || paddr == caf_pkg::ADDR_MSEL_HI || paddr == caf_pkg::ADDR_STATUS
                || paddr == caf_pkg::ADDR_HITS) begin
                addr_ok = 1'b1;
            end else if (paddr >= caf_pkg::ADDR_BPTR_BASE
                         && paddr < caf_pkg::ADDR_BPTR_BASE + 12'h010) begin
                addr_ok = 1'b1;
            end else if (paddr >= caf_pkg::ADDR_MSID_BASE
                         && paddr < caf_pkg::ADDR_MSID_BASE + 12'h00c) begin
                addr_ok = 1'b1;
            end else if (paddr >= caf_pkg::ADDR_MEID_BASE
                         && paddr < caf_pkg::ADDR_MEID_BASE + 12'h00c) begin
                addr_ok = 1'b1;
            end else if (paddr >= caf_pkg::ADDR_FSID_BASE
                         && paddr < caf_pkg::ADDR_FEID_BASE + 12'h040) begin
                addr_ok = 1'b1;     // filter std and ext blocks are adjacent
            end
        end
    end

    // read mux, registered in the setup cycle
    always_comb begin
        rd_next = 32'h00000000;
        if (paddr == caf_pkg::ADDR_FILT_EN) begin
            rd_next[15:0] = filt_en_reg;
        end else if (paddr == caf_pkg::ADDR_MSEL_LO) begin
            rd_next[15:0] = msel_lo_reg;
        end else if (paddr == caf_pkg::ADDR_MSEL_HI) begin
            rd_next[15:0] = msel_hi_reg;
        end else if (paddr == caf_pkg::ADDR_STATUS) begin
            rd_next[caf_pkg::ST_ACCEPT]              = accept_reg;
            rd_next[caf_pkg::ST_FIFO]                = fifo_reg;
            rd_next[caf_pkg::ST_FILT_LO+3:caf_pkg::ST_FILT_LO] = win_reg;
            rd_next[caf_pkg::ST_BUF_LO+3:caf_pkg::ST_BUF_LO]   = buf_reg;
        end else if (paddr == caf_pkg::ADDR_HITS) begin
            rd_next[15:0] = hits_reg;
        end else if (!addr_ok) begin
            rd_next = 32'h00000000;     // unmapped reads zero
        end else if (paddr < caf_pkg::ADDR_MSID_BASE) begin
            rd_next[15:0] = bptr_reg[word[1:0] - 2'h3];
        end else if (paddr < caf_pkg::ADDR_MEID_BASE) begin
            // unimplemented bits read as zero
            rd_next[15:0] = msid_reg[word[1:0]] & caf_pkg::SID_REG_MASK;
        end else if (paddr < caf_pkg::ADDR_FSID_BASE) begin
            rd_next[15:0] = meid_reg[word[1:0]];
        end else if (paddr < caf_pkg::ADDR_FEID_BASE) begin
            rd_next[15:0] = fsid_reg[word] & caf_pkg::SID_REG_MASK;
        end else begin
            rd_next[15:0] = feid_reg[word];
        end
    end

    // read data flop; value stands through the access phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_reg <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_reg <= rd_next;
        end
    end

    // zero wait state: data was captured in setup
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // enables and selection fields with defined reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filt_en_reg <= caf_pkg::FILT_EN_RESET;
            msel_lo_reg <= caf_pkg::ZERO_RESET;
            msel_hi_reg <= caf_pkg::ZERO_RESET;
        end else if (wr_en) begin
            if (paddr == caf_pkg::ADDR_FILT_EN) begin
                filt_en_reg <= pwdata[15:0];
            end
            if (paddr == caf_pkg::ADDR_MSEL_LO) begin
                msel_lo_reg <= pwdata[15:0];
            end
            if (paddr == caf_pkg::ADDR_MSEL_HI) begin
                msel_hi_reg <= pwdata[15:0];
            end
        end
    end

    // buffer pointers, reset to buffer 0 for every filter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                bptr_reg[i] <= caf_pkg::ZERO_RESET;
            end
        end else if (wr_en && paddr >= caf_pkg::ADDR_BPTR_BASE
                     && paddr < caf_pkg::ADDR_MSID_BASE) begin
            bptr_reg[word[1:0] - 2'h3] <= pwdata[15:0];
        end
    end

    // id registers carry no reset: software programs them first
    always_ff @(posedge ref_clk) begin
        if (wr_en && paddr >= caf_pkg::ADDR_MSID_BASE
            && paddr < caf_pkg::ADDR_MEID_BASE) begin
            // writes to bits 4 and 2 are dropped
            msid_reg[word[1:0]] <= pwdata[15:0] & caf_pkg::SID_REG_MASK;
        end
    end

    // mask extended id, no reset
    always_ff @(posedge ref_clk) begin
        if (wr_en && paddr >= caf_pkg::ADDR_MEID_BASE
            && paddr < caf_pkg::ADDR_FSID_BASE) begin
            meid_reg[word[1:0]] <= pwdata[15:0];
        end
    end

    // filter standard id, no reset
    always_ff @(posedge ref_clk) begin
        if (wr_en && paddr >= caf_pkg::ADDR_FSID_BASE
            && paddr < caf_pkg::ADDR_FEID_BASE) begin
            fsid_reg[word] <= pwdata[15:0] & caf_pkg::SID_REG_MASK;
        end
    end

    // filter extended id, no reset
    always_ff @(posedge ref_clk) begin
        if (wr_en && paddr >= caf_pkg::ADDR_FEID_BASE
            && paddr < caf_pkg::ADDR_FEID_BASE + 12'h040) begin
            feid_reg[word] <= pwdata[15:0];
        end
    end

    // one compare unit per filter, mask steered by its source field
    for (genvar k = 0; k < N_FILT; k++) begin : g_filt
        logic [1:0]  src;       // mask source field
        logic [15:0] m_sid;     // steered mask std
        logic [15:0] m_eid;     // steered mask ext

        assign src = msel_all[2*k+1:2*k];
        // reserved code applies no mask at all
        always_comb begin
            case (src)
                2'h0: begin
                    m_sid = msid_reg[0];
                    m_eid = meid_reg[0];
                end
                2'h1: begin
                    m_sid = msid_reg[1];
                    m_eid = meid_reg[1];
                end
                2'h2: begin
                    m_sid = msid_reg[2];
                    m_eid = meid_reg[2];
                end
                default: begin
                    m_sid = caf_pkg::ZERO_RESET;
                    m_eid = caf_pkg::ZERO_RESET;
                end
            endcase
        end

        caf_filter_match u_match (
            .enable    (filt_en_reg[k]),
            .filt_sid  (fsid_reg[k]),
            .filt_eid  (feid_reg[k]),
            .mask_sid  (m_sid),
            .mask_eid  (m_eid),
            .frame_ide (frame_ide),
            .frame_sid (frame_sid),
            .frame_eid (frame_eid),
            .hit       (hit[k])
        );
    end

    // lowest numbered hit wins the frame
    always_comb begin
        any_hit  = 1'b0;
        win_next = 4'h0;
        for (int i = N_FILT - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit  = 1'b1;
                win_next = 4'(i);
            end
        end
    end

    // pointer nibble of the winner, filter k at bits 4k+3:4k
    assign ptr_next = bptr_all[{win_next, 2'h0} +: 4];

    // result captured on the id strobe; later writes do not touch it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            valid_reg  <= 1'b0;
            accept_reg <= 1'b0;
            fifo_reg   <= 1'b0;
            buf_reg    <= 4'h0;
            win_reg    <= 4'h0;
            hits_reg   <= 16'h0000;
        end else begin
            valid_reg <= frame_valid;
            if (frame_valid) begin
                hits_reg   <= hit;
                accept_reg <= any_hit;
                win_reg    <= any_hit ? win_next : 4'h0;
                // all ones routes to the fifo
                fifo_reg   <= any_hit && (ptr_next == caf_pkg::BPTR_FIFO);
                buf_reg    <= (any_hit && ptr_next != caf_pkg::BPTR_FIFO)
                              ? ptr_next : 4'h0;
            end
        end
    end

    // outputs straight from the result flops
    assign result_valid   = valid_reg;
    assign result_accept  = accept_reg;
    assign result_to_fifo = fifo_reg;
    assign result_buffer  = buf_reg;
    assign result_filter  = win_reg;
endmodule

// *** caf_accept_filter_properties.sv ***
// caf_accept_filter_props: port-level checks of the acceptance filter.
// assumes it is bound to caf_accept_filter and sees only its ports.
`timescale 1ns/100ps
module caf_accept_filter_props #(
    parameter int N_FILT = 16,  // filter count
    parameter int N_MASK = 3    // mask count
) (
    input wire logic        ref_clk,        // clock
    input wire logic        rst,            // sync reset, high
    input wire logic        psel,           // apb select
    input wire logic        penable,        // apb access phase
    input wire logic        pwrite,         // apb write
    input wire logic [11:0] paddr,          // apb byte address
    input wire logic [31:0] prdata,         // apb read data
    input wire logic        frame_valid,    // id strobe
    input wire logic        result_valid,   // result strobe
    input wire logic        result_accept,  // some filter hit
    input wire logic        result_to_fifo, // stored in fifo
    input wire logic [3:0]  result_buffer,  // buffer index
    input wire logic [3:0]  result_filter   // winning filter
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // setup cycle of a read from a std id register (mask or filter)
    sequence sid_rd_s;
        psel && !penable && !pwrite && (paddr[11:4] == 8'h02 || paddr[11:6] == 6'h01);
    endsequence
    // frame taken, result one edge later
    sequence frame_s;
        frame_valid ##1 result_valid;
    endsequence
    result_pulse_a: assert property (frame_valid |=> result_valid)
        else $error("result strobe missing after frame");
    no_spurious_a: assert property (!frame_valid |=> !result_valid)
        else $error("result strobe without frame");
    result_hold_a: assert property (!frame_valid |=> $stable({result_accept, result_to_fifo,
        result_buffer, result_filter})) else $error("result changed without frame");
    reject_zero_a: assert property (frame_s ##0 !result_accept |-> !result_to_fifo && result_buffer == 4'h0
        && result_filter == 4'h0) else $error("rejected frame has routing");
    fifo_route_a: assert property (result_to_fifo |-> result_accept && result_buffer == 4'h0)
        else $error("fifo route without accept");
    buffer_range_a: assert property (frame_s ##0 (result_accept && !result_to_fifo) |-> result_buffer <= 4'he)
        else $error("buffer index out of range");
    sid_unimpl_a: assert property (sid_rd_s ##1 penable |-> prdata[4] == 1'b0 && prdata[2] == 1'b0)
        else $error("unimplemented id bits read nonzero");
    reset_clear_a: assert property ($fell(rst) |-> !result_valid && !result_accept && prdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule

// *** caf_frame_src.sv ***
// caf_frame_src: stand-in for the protocol engine, one id strobe a frame.
// assumes the bench calls send from one process, on ref_clk.
`timescale 1ns/100ps
module caf_frame_src (
    input  wire logic        ref_clk,     // clock
    output logic             frame_valid, // id strobe
    output logic             frame_ide,   // extended frame
    output logic [10:0]      frame_sid,   // standard id
    output logic [17:0]      frame_eid    // extended id
);
    // idle lines at time zero
    initial begin
        frame_valid = 1'b0;
        frame_ide = 1'b0;
        frame_sid = 11'h0;
        frame_eid = 18'h0;
    end
    // one frame; after the strobe the id lines carry the inverse,
    // so a design that samples them late cannot pass by luck
    task automatic send(input logic ide, input logic [10:0] sid, input logic [17:0] eid);
        @(posedge ref_clk);
        frame_valid <= 1'b1;
        frame_ide <= ide;
        frame_sid <= sid;
        frame_eid <= eid;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        frame_ide <= ~ide;
        frame_sid <= ~sid;
        frame_eid <= ~eid;
    endtask
endmodule

// *** test_can_acceptance_filter_mask_select.sv ***
// test_can_acceptance_filter_mask_select: self-checking bench.
// assumes caf_pkg, the filter and caf_frame_src are compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_can_acceptance_filter_mask_select;
    typedef struct packed {
        logic        ide;   // extended frame
        logic [10:0] sid;   // standard id
        logic [17:0] eid;   // extended id
        logic        acc;   // accepted
        logic        fifo;  // to fifo
        logic [3:0]  bufi;  // buffer index
        logic [3:0]  filt;  // winning filter
    } caf_row_t;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        frame_valid, frame_ide, result_valid, result_accept, result_to_fifo;
    logic [10:0] frame_sid;
    logic [17:0] frame_eid;
    logic [3:0]  result_buffer, result_filter;
    int          mismatches, n_tests;
    // f0 mask0 full, f1 mask1 strict sid-only, f2 mask2 empty, f3 mask0, f9 mask1
    logic [27:0] cfg [21] = '{28'h000_020f, 28'h020_fff7, 28'h030_ffff, 28'h024_ffe8, 28'h034_0000,
        28'h028_0000, 28'h038_0000, 28'h004_0024, 28'h008_0004, 28'h00c_0ef5, 28'h014_0090,
        28'h040_2460, 28'h080_0000, 28'h044_246b, 28'h084_abcd, 28'h048_2460, 28'h088_0000,
        28'h04c_ffe0, 28'h08c_0000, 28'h064_0aa8, 28'h0a4_0000};
    // frames and the routing they should get
    caf_row_t    rows [9] = '{'{1'b0, 11'h123, 18'h0, 1'b1, 1'b0, 4'h5, 4'h0},
        '{1'b1, 11'h123, 18'h0, 1'b1, 1'b0, 4'h5, 4'h0}, '{1'b1, 11'h123, 18'h3abcd, 1'b1, 1'b1, 4'h0, 4'h1},
        '{1'b1, 11'h123, 18'h10000, 1'b1, 1'b1, 4'h0, 4'h1}, '{1'b1, 11'h124, 18'h0, 1'b0, 1'b0, 4'h0, 4'h0},
        '{1'b0, 11'h124, 18'h0, 1'b1, 1'b0, 4'he, 4'h2}, '{1'b1, 11'h055, 18'h12345, 1'b1, 1'b0, 4'h9, 4'h9},
        '{1'b0, 11'h055, 18'h0, 1'b1, 1'b0, 4'he, 4'h2}, '{1'b0, 11'h7ff, 18'h0, 1'b1, 1'b0, 4'he, 4'h2}};
    caf_accept_filter dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .frame_valid, .frame_ide, .frame_sid, .frame_eid, .result_valid, .result_accept,
        .result_to_fifo, .result_buffer, .result_filter);
    caf_frame_src src (.ref_clk, .frame_valid, .frame_ide, .frame_sid, .frame_eid);
    // 200 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // one apb transfer; waits on pready, only the watchdog bounds the wait
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one frame and its routing result
    task automatic frame(input caf_row_t r);
        src.send(r.ide, r.sid, r.eid);
        #1;
        `CHK(result_valid, 1'b1)
        `CHK({result_accept, result_to_fifo, result_buffer, result_filter}, {r.acc, r.fifo, r.bufi, r.filt})
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, far beyond the 150 or so cycles needed
    initial begin
        #50000;
        mismatches++;
        summarize();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, caf_pkg::ADDR_FILT_EN, 32'h0);
        `CHK(rdat, 32'h0000ffff)
        xfer(1'b0, caf_pkg::ADDR_BPTR_BASE, 32'h0);
        `CHK(rdat, 32'h0)
        foreach (cfg[i]) xfer(1'b1, cfg[i][27:16], {16'h0, cfg[i][15:0]});
        // masks 0-2 all used, several ids and types
        foreach (rows[i]) frame(rows[i]);
        // last frame: std 7ff hits filters 2 and 3, filter 2 wins into buffer 14
        xfer(1'b0, caf_pkg::ADDR_STATUS, 32'h0);
        `CHK(rdat, 32'h0000820e)
        xfer(1'b0, caf_pkg::ADDR_HITS, 32'h0);
        `CHK(rdat, 32'h0000000c)
        xfer(1'b0, caf_pkg::ADDR_MSID_BASE, 32'h0);
        `CHK(rdat, 32'h0000ffe3)
        xfer(1'b0, caf_pkg::ADDR_BPTR_BASE, 32'h0);
        `CHK(rdat, 32'h00000ef5)
        xfer(1'b0, caf_pkg::ADDR_MSEL_LO, 32'h0);
        `CHK(rdat, 32'h00000024)
        // unmapped and misaligned accesses are refused
        xfer(1'b0, 12'h0fc, 32'h0);
        `CHK({err, rdat}, {1'b1, 32'h0})
        xfer(1'b1, 12'h006, 32'h0);
        `CHK(err, 1'b1)
        // filter 0 disabled: the next match wins
        xfer(1'b1, caf_pkg::ADDR_FILT_EN, 32'h0000020e);
        frame('{1'b0, 11'h123, 18'h0, 1'b1, 1'b0, 4'he, 4'h2});
        // enable write on the same edge as a frame: old setting still used
        fork
            xfer(1'b1, caf_pkg::ADDR_FILT_EN, 32'h0000020f);
            begin
                @(posedge ref_clk);
                frame('{1'b0, 11'h123, 18'h0, 1'b1, 1'b0, 4'he, 4'h2});
            end
        join
        frame(rows[0]);
        // second reset in mid-run, raised on a rising edge
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, caf_pkg::ADDR_MSEL_LO, 32'h0);
        `CHK(rdat, 32'h0)
        xfer(1'b0, caf_pkg::ADDR_FILT_EN, 32'h0);
        `CHK(rdat, 32'h0000ffff)
        summarize();
    end
endmodule
bind caf_accept_filter caf_accept_filter_props #(.N_FILT(N_FILT), .N_MASK(N_MASK)) u_props (.ref_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .prdata, .frame_valid, .result_valid, .result_accept, .result_to_fifo,
    .result_buffer, .result_filter);
